// >>> sasc_pkg.sv
package sasc_pkg;
  // register addresses on the plain register port
  localparam logic [7:0] ADDR_RESULT_HIGH = 8'hC4;
  localparam logic [7:0] ADDR_RESULT_LOW = 8'hC5;
  localparam logic [7:0] ADDR_MODE = 8'hC6;
  localparam logic [7:0] ADDR_START = 8'hC7;
  localparam logic [7:0] ADDR_CLK_STOP_1 = 8'hFA;
  localparam logic [7:0] ADDR_PORT_MODE_1 = 8'hE0;
  localparam logic [7:0] ADDR_EDGE_SELECT = 8'hE1;
  localparam logic [7:0] ADDR_IRQ_REQUEST_2 = 8'hE2;
  localparam logic [7:0] ADDR_IRQ_ENABLE_2 = 8'hE3;
  // field positions
  localparam int START_FLAG_BIT = 7;
  localparam int SPEED_BIT = 7;
  localparam int TRG_EN_BIT = 6;
  localparam int CHAN_MSB = 3;
  localparam int STBY_BIT = 4;
  localparam int PIN_FN_BIT = 0;
  localparam int EDGE_SEL_BIT = 0;
  localparam int DONE_REQ_BIT = 0;
  localparam int DONE_IEN_BIT = 0;
  // reset values and bits that always read as one
  localparam logic [7:0] MODE_RST = 8'h30;
  localparam logic [7:0] MODE_FIXED = 8'h30;
  localparam logic [6:0] START_FIXED = 7'h7F;
  localparam logic [7:0] CKSTP_RST = 8'hFF;
  localparam logic [7:0] CKSTP_FIXED = 8'hC0;
  // conversion timing in system clocks
  localparam int RES_BITS = 10;
  localparam int CONV_SLOW_CYC = 62;
  localparam int CONV_FAST_CYC = 31;
  localparam int BIT_SLOW_CYC = 6;
  localparam int BIT_FAST_CYC = 3;
  localparam int SMP_SLOW_CYC = CONV_SLOW_CYC - RES_BITS * BIT_SLOW_CYC;
  localparam int SMP_FAST_CYC = CONV_FAST_CYC - RES_BITS * BIT_FAST_CYC;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_SAMPLE,
    SEQ_CONVERT
  } sasc_seq_t;
endpackage : sasc_pkg

// >>> sasc_sar_if.sv
`timescale 1ns/100ps
interface sasc_sar_if #(parameter int RES_BITS = 10);
  logic start;
  logic abort;
  logic fast;
  logic comp;
  logic done;
  logic sample;
  logic [RES_BITS-1:0] result;
  logic [RES_BITS-1:0] dac;
  modport ctrl (output start, abort, fast, comp,
                input done, sample, result, dac);
  modport seq (input start, abort, fast, comp,
               output done, sample, result, dac);
endinterface : sasc_sar_if

// >>> sasc_sar_seq.sv
`timescale 1ns/100ps
module sasc_sar_seq #(
  parameter int RES_BITS = 10
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  sasc_sar_if.seq sar
);
  localparam int BW = $clog2(RES_BITS);
  localparam logic [5:0] SMP_SLOW = 6'(sasc_pkg::SMP_SLOW_CYC - 1);
  localparam logic [5:0] SMP_FAST = 6'(sasc_pkg::SMP_FAST_CYC - 1);
  localparam logic [5:0] BIT_SLOW = 6'(sasc_pkg::BIT_SLOW_CYC - 1);
  localparam logic [5:0] BIT_FAST = 6'(sasc_pkg::BIT_FAST_CYC - 1);

  if (RES_BITS != sasc_pkg::RES_BITS || sasc_pkg::SMP_FAST_CYC < 1)
  begin : g_bad_cfg
    $error("resolution does not fit the conversion period");
  end

  function automatic logic [RES_BITS-1:0] one_hot(input logic [BW-1:0] b);
    one_hot = '0;
    one_hot[b] = 1'b1;
  endfunction : one_hot

  sasc_pkg::sasc_seq_t state_ff, nxt_state;
  logic [5:0] cnt_ff, nxt_cnt;
  logic [BW-1:0] bit_ff, nxt_bit;
  logic [RES_BITS-1:0] sar_ff, nxt_sar, dac_ff, nxt_dac;
  logic sample_ff;

  wire [5:0] bit_len = sar.fast ? BIT_FAST : BIT_SLOW;
  wire [5:0] smp_len = sar.fast ? SMP_FAST : SMP_SLOW;
  wire in_conv = (state_ff == sasc_pkg::SEQ_CONVERT);
  wire step_end = in_conv && (cnt_ff == 6'h00);
  // keep the trial bit when the comparator says input >= trial level
  wire [RES_BITS-1:0] kept = sar.comp ? dac_ff : sar_ff;

  assign sar.done = step_end && (bit_ff == '0) && !sar.abort;
  assign sar.result = kept;
  assign sar.dac = dac_ff;
  assign sar.sample = sample_ff;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_bit = bit_ff;
    nxt_sar = sar_ff;
    nxt_dac = dac_ff;
    unique case (state_ff)
      sasc_pkg::SEQ_IDLE:
        if (sar.start)
        begin
          nxt_state = sasc_pkg::SEQ_SAMPLE;
          nxt_cnt = smp_len;
          nxt_sar = '0;
          nxt_dac = '0;
        end
      sasc_pkg::SEQ_SAMPLE:
        if (cnt_ff == 6'h00)
        begin
          nxt_state = sasc_pkg::SEQ_CONVERT;
          nxt_cnt = bit_len;
          nxt_bit = BW'(RES_BITS - 1);
          nxt_dac = one_hot(BW'(RES_BITS - 1));
        end
        else
          nxt_cnt = cnt_ff - 6'h01;
      sasc_pkg::SEQ_CONVERT:
        if (cnt_ff != 6'h00)
          nxt_cnt = cnt_ff - 6'h01;
        else if (bit_ff == '0)
        begin
          nxt_state = sasc_pkg::SEQ_IDLE;
          nxt_sar = kept;
          nxt_dac = kept;
        end
        else
        begin
          nxt_sar = kept;
          nxt_bit = bit_ff - BW'(1);
          nxt_cnt = bit_len;
          nxt_dac = kept | one_hot(bit_ff - BW'(1));
        end
      default:
        nxt_state = sasc_pkg::SEQ_IDLE;
    endcase
    if (sar.abort)
      nxt_state = sasc_pkg::SEQ_IDLE;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      state_ff <= sasc_pkg::SEQ_IDLE;
      cnt_ff <= 6'h00;
      bit_ff <= '0;
      sar_ff <= '0;
      dac_ff <= '0;
      sample_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      bit_ff <= nxt_bit;
      sar_ff <= nxt_sar;
      dac_ff <= nxt_dac;
      sample_ff <= (nxt_state == sasc_pkg::SEQ_SAMPLE);
    end
  end

  msb_first_a: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    $rose(in_conv) |-> dac_ff == one_hot(BW'(RES_BITS - 1)))
    else $error("first trial is not the top bit");
endmodule : sasc_sar_seq

// >>> sasc_top.sv
// Operation
// - software writing one starts a conversion
// - enabled trigger pin edge sets start flag
// - flag holds during conversion, self-clears after
// - result loaded in the flag-clearing cycle
// - writing zero stops conversion, back to idle
// - start flag reads busy state, resets zero
// - low seven start bits read one
// - conversion end sets done request flag
// - interrupt requested only while enable set
// - successive approximation gives ten-bit result
// - standby bit zero stops the converter
// - reset clears mode/start, keeps results
// - channel code 0101 selects input one
// - channel codes map to eight inputs
// - speed bit picks 62 or 31 clocks
// - high eight bits, low two bits placement
//
// Our own choices: the address map and strobed register access.
`timescale 1ns/100ps
module sasc_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  input wire logic i_ext_trigger_pin,
  input wire logic i_comp,
  output logic [9:0] o_dac_code,
  output logic o_sample,
  output logic [7:0] o_chan_sel,
  output logic o_conv_irq
);
  localparam int RB = sasc_pkg::RES_BITS;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    hit = (a == r);
  endfunction : hit

  function automatic logic [7:0] chan_dec(input logic [3:0] c);
    chan_dec = 8'h00;
    if (c[3:2] == 2'b01)
      chan_dec[{1'b0, c[1:0]}] = 1'b1;
    else if (c[3:2] == 2'b10)
      chan_dec[{1'b1, c[1:0]}] = 1'b1;
  endfunction : chan_dec

  sasc_sar_if #(.RES_BITS(RB)) sar ();

  sasc_sar_seq #(.RES_BITS(RB)) u_seq (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .sar(sar.seq)
  );

  logic [7:0] mode_ff;
  logic flag_ff;
  logic [7:0] ckstp_ff;
  logic pin_fn_ff;
  logic edge_sel_ff;
  logic req_ff;
  logic ien_ff;
  logic [7:0] res_h_ff;
  logic [1:0] res_l_ff;
  logic trig_d_ff;
  logic irq_ff;
  logic [7:0] chan_ff;
  logic [7:0] rd_data_ff;
  logic nxt_flag;
  logic nxt_req;
  logic [7:0] rd_val;

  // register port decode
  wire wr_mode = i_wr && hit(i_addr, sasc_pkg::ADDR_MODE);
  wire wr_start = i_wr && hit(i_addr, sasc_pkg::ADDR_START);
  wire wr_ckstp = i_wr && hit(i_addr, sasc_pkg::ADDR_CLK_STOP_1);
  wire wr_pmr = i_wr && hit(i_addr, sasc_pkg::ADDR_PORT_MODE_1);
  wire wr_edge = i_wr && hit(i_addr, sasc_pkg::ADDR_EDGE_SELECT);
  wire wr_req = i_wr && hit(i_addr, sasc_pkg::ADDR_IRQ_REQUEST_2);
  wire wr_ien = i_wr && hit(i_addr, sasc_pkg::ADDR_IRQ_ENABLE_2);
  wire wbit7 = i_wdata[sasc_pkg::START_FLAG_BIT];

  // standby bit zero holds the converter off
  wire active = ckstp_ff[sasc_pkg::STBY_BIT];
  wire trg_en = mode_ff[sasc_pkg::TRG_EN_BIT];
  wire fast = mode_ff[sasc_pkg::SPEED_BIT];

  wire trig_edge = edge_sel_ff ? (i_ext_trigger_pin && !trig_d_ff)
                               : (!i_ext_trigger_pin && trig_d_ff);
  wire trig_start = active && pin_fn_ff && trg_en && trig_edge;

  wire sw_start = wr_start && wbit7 && active;
  wire sw_stop = wr_start && !wbit7;
  wire start = (sw_start || trig_start) && !flag_ff && !sw_stop;
  wire abort = flag_ff && (sw_stop || !active);
  wire done = sar.done && flag_ff;

  assign sar.start = start;
  assign sar.abort = abort;
  assign sar.fast = fast;
  assign sar.comp = i_comp;

  // flag holds, clears on completion or stop
  always_comb
  begin
    nxt_flag = flag_ff;
    if (start)
      nxt_flag = 1'b1;
    if (done || abort)
      nxt_flag = 1'b0;
  end

  // done request; a set in the clear cycle wins
  always_comb
  begin
    nxt_req = req_ff;
    if (wr_req && !i_wdata[sasc_pkg::DONE_REQ_BIT])
      nxt_req = 1'b0;
    if (done)
      nxt_req = 1'b1;
  end

  // read view; unmapped addresses read zero
  always_comb
  begin
    rd_val = 8'h00;
    unique case (1'b1)
      hit(i_addr, sasc_pkg::ADDR_MODE):
        rd_val = mode_ff | sasc_pkg::MODE_FIXED;
      hit(i_addr, sasc_pkg::ADDR_START):
        rd_val = {flag_ff, sasc_pkg::START_FIXED};
      hit(i_addr, sasc_pkg::ADDR_RESULT_HIGH):
        rd_val = res_h_ff;
      hit(i_addr, sasc_pkg::ADDR_RESULT_LOW):
        rd_val = {res_l_ff, 6'h00};
      hit(i_addr, sasc_pkg::ADDR_CLK_STOP_1):
        rd_val = ckstp_ff | sasc_pkg::CKSTP_FIXED;
      hit(i_addr, sasc_pkg::ADDR_PORT_MODE_1):
        rd_val = {7'h00, pin_fn_ff};
      hit(i_addr, sasc_pkg::ADDR_EDGE_SELECT):
        rd_val = {7'h00, edge_sel_ff};
      hit(i_addr, sasc_pkg::ADDR_IRQ_REQUEST_2):
        rd_val = {7'h00, req_ff};
      hit(i_addr, sasc_pkg::ADDR_IRQ_ENABLE_2):
        rd_val = {7'h00, ien_ff};
      default:
        rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      mode_ff <= sasc_pkg::MODE_RST;
      flag_ff <= 1'b0;
      ckstp_ff <= sasc_pkg::CKSTP_RST;
    end
    else
    begin
      if (wr_mode)
        mode_ff <= i_wdata | sasc_pkg::MODE_FIXED;
      flag_ff <= nxt_flag;
      if (wr_ckstp)
        ckstp_ff <= i_wdata | sasc_pkg::CKSTP_FIXED;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      pin_fn_ff <= 1'b0;
      edge_sel_ff <= 1'b0;
      ien_ff <= 1'b0;
      req_ff <= 1'b0;
    end
    else
    begin
      if (wr_pmr)
        pin_fn_ff <= i_wdata[sasc_pkg::PIN_FN_BIT];
      if (wr_edge)
        edge_sel_ff <= i_wdata[sasc_pkg::EDGE_SEL_BIT];
      if (wr_ien)
        ien_ff <= i_wdata[sasc_pkg::DONE_IEN_BIT];
      req_ff <= nxt_req;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      trig_d_ff <= 1'b0;
      irq_ff <= 1'b0;
      chan_ff <= 8'h00;
      rd_data_ff <= 8'h00;
    end
    else
    begin
      trig_d_ff <= i_ext_trigger_pin;
      irq_ff <= req_ff && ien_ff;
      chan_ff <= chan_dec(mode_ff[sasc_pkg::CHAN_MSB:0]);
      rd_data_ff <= i_rd ? rd_val : 8'h00;
    end
  end

  // results survive reset, so no reset branch
  always_ff @(posedge i_clk)
  begin
    if (done)
    begin
      res_h_ff <= sar.result[RB-1:RB-8];
      res_l_ff <= sar.result[1:0];
    end
  end

  assign o_rd_data = rd_data_ff;
  assign o_dac_code = sar.dac;
  assign o_sample = sar.sample;
  assign o_chan_sel = chan_ff;
  assign o_conv_irq = irq_ff;

  // cycles spent with the flag set, for the period check
  logic [6:0] busy_cnt_ff;
  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n || !flag_ff)
      busy_cnt_ff <= 7'h00;
    else
      busy_cnt_ff <= busy_cnt_ff + 7'h01;
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  sw_start_a: assert property (
    wr_start && wbit7 && active && !flag_ff |=> flag_ff)
    else $error("software start did not raise the flag");

  trig_start_a: assert property (
    $rose(flag_ff) |-> $past(sw_start || trig_start))
    else $error("flag rose without an enabled cause");

  trig_edge_a: assert property (
    !flag_ff && pin_fn_ff && trg_en && active && !edge_sel_ff
    && trig_d_ff && !i_ext_trigger_pin && !wr_start |=> flag_ff)
    else $error("falling trigger edge ignored");

  flag_hold_a: assert property (
    flag_ff && !done && !abort |=> flag_ff)
    else $error("flag dropped during conversion");

  done_load_a: assert property (
    done |=> !flag_ff && res_h_ff == $past(sar.result[9:2])
    && res_l_ff == $past(sar.result[1:0]))
    else $error("result not loaded with flag clear");

  stop_idle_a: assert property (
    flag_ff && sw_stop |=> !flag_ff && !o_sample && $stable(req_ff))
    else $error("stop write did not end conversion");

  start_read_a: assert property (
    i_rd && hit(i_addr, sasc_pkg::ADDR_START)
    |=> o_rd_data == {$past(flag_ff), 7'h7F})
    else $error("start register read wrong");

  req_set_a: assert property (
    $fell(flag_ff) && $past(done) |-> req_ff)
    else $error("done request not set");

  irq_gate_a: assert property (
    o_conv_irq |-> $past(ien_ff) && $past(req_ff))
    else $error("interrupt without enable");

  period_a: assert property (
    done |-> busy_cnt_ff == (fast ? 7'(sasc_pkg::CONV_FAST_CYC - 1)
                                  : 7'(sasc_pkg::CONV_SLOW_CYC - 1)))
    else $error("conversion period wrong");

  standby_a: assert property (
    !active |=> !flag_ff)
    else $error("converter ran in standby");

  no_restart_a: assert property (
    flag_ff && $past(flag_ff) |-> !$rose(o_sample))
    else $error("running conversion restarted");

  chan_one_a: assert property (
    mode_ff[3:0] == 4'h5 |=> o_chan_sel == 8'h02)
    else $error("code 0101 did not pick input one");

  trig_rise_a: assert property (
    !flag_ff && pin_fn_ff && trg_en && active && edge_sel_ff
    && !trig_d_ff && i_ext_trigger_pin && !wr_start |=> flag_ff)
    else $error("rising trigger edge ignored");

  req_win_a: assert property (
    done && wr_req && !i_wdata[sasc_pkg::DONE_REQ_BIT] |=> req_ff)
    else $error("request clear beat the done event");

  irq_set_a: assert property (
    req_ff && ien_ff |=> o_conv_irq)
    else $error("enabled request gave no interrupt");

  low_read_a: assert property (
    i_rd && hit(i_addr, sasc_pkg::ADDR_RESULT_LOW)
    |=> o_rd_data[5:0] == 6'h00)
    else $error("unused result bits not zero");

  abort_keep_a: assert property (
    abort |=> $stable(res_h_ff) && $stable(res_l_ff))
    else $error("stopped conversion loaded a result");

  sample_start_a: assert property (
    $rose(flag_ff) |-> o_sample)
    else $error("conversion began without sampling");

  ckstp_fixed_a: assert property (
    i_rd && hit(i_addr, sasc_pkg::ADDR_CLK_STOP_1)
    |=> o_rd_data[7:6] == 2'h3)
    else $error("fixed clock stop bits not one");

  sw_done_c: cover property (sw_start ##1 flag_ff [*8] ##[1:80] done);
  trig_done_c: cover property (trig_start ##[1:80] done);
  stop_c: cover property (flag_ff && sw_stop);
  irq_c: cover property (done ##[1:3] o_conv_irq);
  trig_rise_c: cover property (trig_start && edge_sel_ff);
endmodule : sasc_top

// >>> sasc_analog_src.sv
`timescale 1ns/100ps
module sasc_analog_src (
  input wire logic i_clk,
  input wire logic [7:0] i_chan_sel,
  input wire logic i_sample,
  input wire logic [9:0] i_dac_code,
  input wire logic i_trig_drive,
  output logic o_comp,
  output logic o_ext_trigger_pin
);
  logic [9:0] held_ff = 10'h000;
  logic trig_ff = 1'b0;

  always @(posedge i_clk)
  begin
    trig_ff <= i_trig_drive;
    if (i_sample)
    begin
      held_ff <= 10'h000;
      for (int n = 0; n < 8; n++)
        if (i_chan_sel[n])
          held_ff <= 10'h0A5 + 10'(n) * 10'h070;
    end
  end

  assign o_comp = (held_ff >= i_dac_code);
  // the pin moves only on a clock edge, like a synchronised input
  assign o_ext_trigger_pin = trig_ff;
endmodule : sasc_analog_src

// >>> sasc_top_tb.sv
`timescale 1ns/100ps
module sasc_top_tb;
  localparam logic [7:0] A_ST = sasc_pkg::ADDR_START;
  localparam logic [7:0] A_MD = sasc_pkg::ADDR_MODE;
  localparam logic [7:0] A_CK = sasc_pkg::ADDR_CLK_STOP_1;
  localparam logic [7:0] A_RQ = sasc_pkg::ADDR_IRQ_REQUEST_2;
  localparam logic [7:0] A_EN = sasc_pkg::ADDR_IRQ_ENABLE_2;
  logic i_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic trig_drive = 1'b0;
  logic pin;
  logic comp;
  logic [7:0] o_rd_data;
  logic [9:0] o_dac_code;
  logic o_sample;
  logic [7:0] o_chan_sel;
  logic o_conv_irq;
  logic [7:0] rd_val;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t0 = 0;

  always #20 i_clk = ~i_clk;

  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
  end

  sasc_top i_dut (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rd_data(o_rd_data),
    .i_ext_trigger_pin(pin),
    .i_comp(comp),
    .o_dac_code(o_dac_code),
    .o_sample(o_sample),
    .o_chan_sel(o_chan_sel),
    .o_conv_irq(o_conv_irq)
  );

  sasc_analog_src i_src (
    .i_clk(i_clk),
    .i_chan_sel(o_chan_sel),
    .i_sample(o_sample),
    .i_dac_code(o_dac_code),
    .i_trig_drive(trig_drive),
    .o_comp(comp),
    .o_ext_trigger_pin(pin)
  );

  function automatic logic [9:0] lvl(input int n);
    return 10'h0A5 + 10'(n) * 10'h070;
  endfunction : lvl

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    rd_val = o_rd_data;
  endtask : rd

  task automatic wait_irq;
    int n;
    n = 0;
    while (o_conv_irq !== 1'b1)
    begin
      @(posedge i_clk);
      #1;
      n++;
      if (n > 200)
      begin
        chk("irq wait", 16'h0001, 16'h0000);
        close_out();
      end
    end
  endtask : wait_irq

  task automatic reset_dut(input logic keep, input logic [7:0] hi);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    rd(A_MD);
    chk("mode reset", 16'h0030, 16'(rd_val));
    rd(A_ST);
    chk("start reset", 16'h007F, 16'(rd_val));
    rd(A_CK);
    chk("clock stop reset", 16'h00FF, 16'(rd_val));
    wr(8'h00, 8'hFF);
    rd(8'h00);
    chk("unmapped", 16'h0000, 16'(rd_val));
    if (keep)
    begin
      rd(sasc_pkg::ADDR_RESULT_HIGH);
      chk("result kept", 16'(hi), 16'(rd_val));
    end
  endtask : reset_dut

  // trg set: start by pin edge toward level ed instead of a write
  task automatic conv(input logic fast, input logic trg, input int ch,
                      input logic ed);
    logic [9:0] lv;
    int per;
    lv = lvl(ch);
    per = fast ? sasc_pkg::CONV_FAST_CYC : sasc_pkg::CONV_SLOW_CYC;
    // park the pin opposite the chosen edge while the trigger is off
    wr(A_MD, 8'h30);
    trig_drive <= ~ed;
    wr(A_RQ, 8'h00);
    wr(sasc_pkg::ADDR_EDGE_SELECT, {7'h00, ed});
    wr(sasc_pkg::ADDR_PORT_MODE_1, 8'h01);
    wr(A_MD, {fast, trg, 2'h3, 4'(ch + 4)});
    if (trg)
    begin
      trig_drive <= ed;
      // the pin moves one edge later, the flag one edge after that
      repeat (2) @(posedge i_clk);
      t0 = cyc;
    end
    else
    begin
      wr(A_ST, 8'h80);
      t0 = cyc;
    end
    #1;
    chk("sampling", 16'h0001, 16'(o_sample));
    rd(A_ST);
    chk("busy flag", 16'h00FF, 16'(rd_val));
    chk("chan sel", 16'(8'h01 << ch), 16'(o_chan_sel));
    wr(A_ST, 8'h80);
    trig_drive <= ~ed;
    repeat (2) @(posedge i_clk);
    trig_drive <= ed;
    wait_irq();
    chk("period", 16'(per + 2), 16'(cyc - t0));
    rd(A_ST);
    chk("flag done", 16'h007F, 16'(rd_val));
    rd(sasc_pkg::ADDR_RESULT_HIGH);
    chk("result high", 16'(lv[9:2]), 16'(rd_val));
    rd(sasc_pkg::ADDR_RESULT_LOW);
    chk("result low", 16'({lv[1:0], 6'h00}), 16'(rd_val));
  endtask : conv

  task automatic trig_off;
    // falling edge chosen; each pass clears one of the two enables
    for (int k = 0; k < 2; k++)
    begin
      wr(sasc_pkg::ADDR_PORT_MODE_1, 8'(k));
      wr(A_MD, k ? 8'h35 : 8'h75);
      trig_drive <= 1'b1;
      repeat (4) @(posedge i_clk);
      trig_drive <= 1'b0;
      repeat (4) @(posedge i_clk);
      rd(A_ST);
      chk("trigger disabled", 16'h007F, 16'(rd_val));
    end
  endtask : trig_off

  task automatic abort_conv;
    wr(A_RQ, 8'h00);
    wr(A_ST, 8'h80);
    repeat (20) @(posedge i_clk);
    wr(A_ST, 8'h00);
    rd(A_ST);
    chk("stopped flag", 16'h007F, 16'(rd_val));
    repeat (70) @(posedge i_clk);
    rd(A_RQ);
    chk("no request", 16'h0000, 16'(rd_val[0]));
    chk("no irq", 16'h0000, 16'(o_conv_irq));
  endtask : abort_conv

  task automatic irq_mask;
    wr(A_EN, 8'h00);
    wr(A_RQ, 8'h00);
    wr(A_ST, 8'h80);
    repeat (70) @(posedge i_clk);
    #1;
    chk("irq masked", 16'h0000, 16'(o_conv_irq));
    rd(A_RQ);
    chk("done request", 16'h0001, 16'(rd_val[0]));
    wr(A_EN, 8'h01);
    repeat (2) @(posedge i_clk);
    #1;
    chk("irq enabled", 16'h0001, 16'(o_conv_irq));
  endtask : irq_mask

  task automatic standby;
    // a running conversion is cut short by the standby bit
    wr(A_ST, 8'h80);
    wr(A_CK, 8'h00);
    rd(A_ST);
    chk("standby abort", 16'h007F, 16'(rd_val));
    rd(A_CK);
    chk("clock stop", 16'h00C0, 16'(rd_val));
    wr(A_ST, 8'h80);
    rd(A_ST);
    chk("standby start", 16'h007F, 16'(rd_val));
    wr(A_CK, 8'hFF);
    repeat (10) @(posedge i_clk);
  endtask : standby

  initial
  begin
    reset_dut(1'b0, 8'h00);
    wr(A_EN, 8'h01);
    conv(1'b0, 1'b0, 1, 1'b0);
    conv(1'b1, 1'b0, 7, 1'b0);
    trig_off();
    conv(1'b0, 1'b1, 3, 1'b1);
    conv(1'b1, 1'b1, 4, 1'b0);
    abort_conv();
    irq_mask();
    standby();
    conv(1'b1, 1'b0, 2, 1'b0);
    reset_dut(1'b1, 8'(lvl(2) >> 2));
    close_out();
  end
endmodule : sasc_top_tb
